// ==== hdl/crs_defs.vh ====
// Constants for the clock ratio select block: register offsets, reset word
// field positions, reset values and ratio encodings.
// Assumes inclusion by the block's single design file only.
`ifndef CRS_DEFS_VH
`define CRS_DEFS_VH

// Register word indices on the Avalon-MM slave.
`define CRS_OFS_CFG_LOW      4'h0
`define CRS_OFS_CFG_HIGH     4'h1
`define CRS_OFS_OUT_CLK_CTL  4'h2
`define CRS_OFS_LOCAL_RATIO  4'h3
`define CRS_OFS_UNIT_CLK     4'h4
`define CRS_OFS_RATIO_STAT   4'h5
`define CRS_OFS_ENGINE_STAT  4'h6

// Reset configuration low word fields.
`define CRS_LOW_SYSTEM_PLL_MULTIPLIER_HI      27
`define CRS_LOW_SYSTEM_PLL_MULTIPLIER_LO      24
`define CRS_LOW_CORE_HI      22
`define CRS_LOW_CORE_LO      16
`define CRS_LOW_ENGINE_PLL_MULTIPLIER_HI     12
`define CRS_LOW_ENGINE_PLL_MULTIPLIER_LO     8
`define CRS_LOW_ENGINE_PLL_DIVIDER        6
`define CRS_LOW_MEMDBL       30
`define CRS_LOW_LBDBL        31

// Reset configuration high word fields.
`define CRS_HIGH_HOST        31
`define CRS_HIGH_CKDRV       30

// System multiplier encodings.
`define CRS_SYSTEM_PLL_MULTIPLIER_X16         4'h0
`define CRS_SYSTEM_PLL_MULTIPLIER_RSVD        4'h1
`define CRS_MULT_16          5'h10

// Primary clock source codes.
`define CRS_SRC_OSC          2'h0
`define CRS_SRC_AGENT        2'h1
`define CRS_SRC_SYNC         2'h2

// Local bus divider field codes.
`define CRS_LDIV_2           2'h0
`define CRS_LDIV_4           2'h1
`define CRS_LDIV_8           2'h2

// Security unit rate codes.
`define CRS_SEC_OFF          2'h0
`define CRS_SEC_FULL         2'h1
`define CRS_SEC_HALF         2'h2
`define CRS_SEC_THIRD        2'h3

// Reset values of the writable registers.
`define CRS_RST_OUT_CLK_CTL  3'h0
`define CRS_RST_LOCAL_DIV    2'h0
`define CRS_RST_SEC_RATE     2'h3
`define CRS_RST_DMA_ON       1'h1

// Boundary counts for glitch-free ratio changes.
`define CRS_LCNT_WRAP        3'h7
`define CRS_UCNT_WRAP        3'h5

`endif

// ==== hdl/crs_clock_ratio_select.v ====
// Clock source selection and ratio control for the system clock unit.
// Assumes all pin inputs are synchronous to CORE_CLK, which stands in for the
// system bus clock and for both controller clocks when divided outputs are formed.
//
// Chosen here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`include "crs_defs.vh"

module crs_clock_ratio_select (
   input wire CORE_CLK,
   input wire SRST,
   input wire [31:0] RESET_CONFIG_LOW,
   input wire [31:0] RESET_CONFIG_HIGH,
   input wire INPUT_HALVE_STRAP,
   input wire OSC_CLOCK_IN,
   input wire AGENT_BUS_CLK,
   input wire SYNC_LOOP_IN,
   input wire [3:0] AVS_ADDRESS,
   input wire AVS_READ,
   input wire AVS_WRITE,
   input wire [31:0] AVS_WRITEDATA,
   input wire [3:0] AVS_BYTEENABLE,
   output reg [31:0] AVS_READDATA,
   output reg AVS_WAITREQUEST,
   output reg [1:0] PRIMARY_SEL,
   output reg PRIMARY_CLK,
   output reg SYNC_LOOP_OUT,
   output reg [2:0] BUS_CLOCK_OUTS,
   output reg [5:0] SYSTEM_RATIO,
   output reg [6:0] CORE_PLL_SETTING,
   output reg [4:0] ENGINE_MULT,
   output reg [1:0] ENGINE_DIV,
   output reg [6:0] MEMORY_RATIO,
   output reg [6:0] LOCAL_RATIO,
   output reg MEMORY_CLOCK_P,
   output reg MEMORY_CLOCK_N,
   output reg [2:0] LOCAL_BUS_CLOCKS,
   output reg LOCAL_SYNC_OUT,
   output reg SEC_CLK_EN,
   output reg DMA_CLK_EN
);

   // Reset word snapshot and role decode.
   reg [31:0] cfg_low_q;
   reg [31:0] cfg_high_q;
   reg halve_q;
   reg osc_prev_q;
   reg bus_div_q;
   reg [2:0] bus_gate_q;
   reg [2:0] out_clk_ctl_q;
   reg [1:0] local_div_q;
   reg [1:0] local_div_act_q;
   reg [2:0] local_cnt_q;
   reg mem_div_q;
   reg [1:0] sec_rate_q;
   reg [1:0] sec_rate_act_q;
   reg dma_on_q;
   reg dma_on_act_q;
   reg [2:0] unit_cnt_q;
   reg [31:0] rdata_d;
   wire host_role_bit;
   wire bus_clock_drive_bit;
   wire host_drive;
   wire [3:0] system_pll_multiplier;
   wire [4:0] sys_mult;
   wire [5:0] sys_ratio;
   wire osc_rise;
   wire bus_div_d;
   wire [2:0] local_cnt_d;
   wire [2:0] unit_cnt_d;
   wire bus_hit;
   wire system_pll_multiplier_reserved;
   reg [1:0] src_d;
   reg local_clk_d;
   reg sec_en_d;

   // Multiplier code 0 means sixteen; code 1 is reserved and is flagged in status.
   function [4:0] crs_sys_mult;
      input [3:0] code;
      begin
         if (code == `CRS_SYSTEM_PLL_MULTIPLIER_X16)
            crs_sys_mult = `CRS_MULT_16;
         else
            crs_sys_mult = {1'b0, code};
      end
   endfunction

   // Applies a doubler bit to the system ratio.
   function [6:0] crs_double;
      input [5:0] ratio;
      input dbl;
      begin
         crs_double = dbl ? {ratio, 1'b0} : {1'b0, ratio};
      end
   endfunction

   assign host_role_bit = cfg_high_q[`CRS_HIGH_HOST];
   assign bus_clock_drive_bit = cfg_high_q[`CRS_HIGH_CKDRV];
   assign host_drive = host_role_bit & bus_clock_drive_bit;
   assign system_pll_multiplier = cfg_low_q[`CRS_LOW_SYSTEM_PLL_MULTIPLIER_HI:`CRS_LOW_SYSTEM_PLL_MULTIPLIER_LO];
   assign sys_mult = crs_sys_mult(system_pll_multiplier);
   assign system_pll_multiplier_reserved = (system_pll_multiplier == `CRS_SYSTEM_PLL_MULTIPLIER_RSVD);
   // Strap doubles the system ratio in host and agent mode alike; the role does not gate it.
   assign sys_ratio = halve_q ? {sys_mult, 1'b0} : {1'b0, sys_mult};
   assign osc_rise = OSC_CLOCK_IN & ~osc_prev_q;
   assign bus_div_d = osc_rise ? ~bus_div_q : bus_div_q;
   assign local_cnt_d = local_cnt_q + 3'h1;
   assign unit_cnt_d = (unit_cnt_q == `CRS_UCNT_WRAP) ? 3'h0 : unit_cnt_q + 3'h1;
   assign bus_hit = (AVS_READ | AVS_WRITE) & AVS_WAITREQUEST;

   // Primary source decode.
   always @*
   begin
      if (!host_role_bit)
         src_d = `CRS_SRC_AGENT;
      else if (bus_clock_drive_bit)
         src_d = `CRS_SRC_OSC;
      else
         src_d = `CRS_SRC_SYNC;
   end

   // Local bus clock is one bit of a free counter, chosen by the active divider.
   always @*
   begin
      case (local_div_act_q)
         `CRS_LDIV_2: local_clk_d = local_cnt_d[0];
         `CRS_LDIV_4: local_clk_d = local_cnt_d[1];
         default: local_clk_d = local_cnt_d[2];
      endcase
   end

   // Security unit enable pattern over a six-cycle frame.
   always @*
   begin
      case (sec_rate_act_q)
         `CRS_SEC_OFF: sec_en_d = 1'b0;
         `CRS_SEC_FULL: sec_en_d = 1'b1;
         `CRS_SEC_HALF: sec_en_d = ~unit_cnt_d[0];
         default: sec_en_d = (unit_cnt_d == 3'h0) || (unit_cnt_d == 3'h3);
      endcase
   end

   // Read mux.
   always @*
   begin
      rdata_d = 32'h0;
      case (AVS_ADDRESS)
         `CRS_OFS_CFG_LOW: rdata_d = cfg_low_q;
         `CRS_OFS_CFG_HIGH: rdata_d = cfg_high_q;
         `CRS_OFS_OUT_CLK_CTL: rdata_d = {29'h0, out_clk_ctl_q};
         `CRS_OFS_LOCAL_RATIO: rdata_d = {30'h0, local_div_q};
         `CRS_OFS_UNIT_CLK: rdata_d = {29'h0, dma_on_q, sec_rate_q};
         // Status packs the live ratios so software can confirm the captured reset word.
         `CRS_OFS_RATIO_STAT:
            rdata_d = {1'b0,
               system_pll_multiplier_reserved,
               LOCAL_RATIO,
               MEMORY_RATIO,
               SYSTEM_RATIO,
               host_drive,
               halve_q,
               PRIMARY_SEL,
               ENGINE_DIV[0],
               ENGINE_MULT[1:0],
               3'h0};
         `CRS_OFS_ENGINE_STAT: rdata_d = {9'h0, CORE_PLL_SETTING, 9'h0, ENGINE_DIV, ENGINE_MULT};
         default: rdata_d = 32'h0;
      endcase
   end

   // Configuration capture and derived ratios.
   always @(posedge CORE_CLK)
   begin
      if (SRST)
      begin
         // The reset word and strap are caught while reset is held.
         cfg_low_q <= RESET_CONFIG_LOW;
         cfg_high_q <= RESET_CONFIG_HIGH;
         halve_q <= INPUT_HALVE_STRAP;
         PRIMARY_SEL <= `CRS_SRC_OSC;
         SYSTEM_RATIO <= 6'h0;
         CORE_PLL_SETTING <= 7'h0;
         ENGINE_MULT <= 5'h0;
         ENGINE_DIV <= 2'h0;
         MEMORY_RATIO <= 7'h0;
         LOCAL_RATIO <= 7'h0;
      end
      else
      begin
         PRIMARY_SEL <= src_d;
         SYSTEM_RATIO <= sys_ratio;
         CORE_PLL_SETTING <= cfg_low_q[`CRS_LOW_CORE_HI:`CRS_LOW_CORE_LO];
         ENGINE_MULT <= cfg_low_q[`CRS_LOW_ENGINE_PLL_MULTIPLIER_HI:`CRS_LOW_ENGINE_PLL_MULTIPLIER_LO];
         ENGINE_DIV <= {1'b0, cfg_low_q[`CRS_LOW_ENGINE_PLL_DIVIDER]} + 2'h1;
         MEMORY_RATIO <= crs_double(sys_ratio, cfg_low_q[`CRS_LOW_MEMDBL]);
         LOCAL_RATIO <= crs_double(sys_ratio, cfg_low_q[`CRS_LOW_LBDBL]);
      end
   end

   // Primary clock and the host-driven bus clock family.
   always @(posedge CORE_CLK)
   begin
      if (SRST)
      begin
         // Seeding the edge detector with the pin keeps a high oscillator at release
         // from counting as a rising edge and slipping the bus divider phase.
         osc_prev_q <= OSC_CLOCK_IN;
         bus_div_q <= 1'b0;
         bus_gate_q <= 3'h0;
         PRIMARY_CLK <= 1'b0;
         SYNC_LOOP_OUT <= 1'b0;
         BUS_CLOCK_OUTS <= 3'h0;
      end
      else
      begin
         osc_prev_q <= OSC_CLOCK_IN;
         bus_div_q <= bus_div_d;
         case (PRIMARY_SEL)
            `CRS_SRC_OSC: PRIMARY_CLK <= OSC_CLOCK_IN;
            `CRS_SRC_AGENT: PRIMARY_CLK <= AGENT_BUS_CLK;
            default: PRIMARY_CLK <= SYNC_LOOP_IN;
         endcase
         // Gates move only while the divided clock is low, so no runt reaches a pin.
         if (!bus_div_q && !bus_div_d)
            bus_gate_q <= out_clk_ctl_q;
         if (host_drive)
         begin
            SYNC_LOOP_OUT <= halve_q ? bus_div_d : OSC_CLOCK_IN;
            BUS_CLOCK_OUTS <= {3{bus_div_d}} & bus_gate_q;
         end
         else
         begin
            SYNC_LOOP_OUT <= 1'b0;
            BUS_CLOCK_OUTS <= 3'h0;
         end
      end
   end

   // Memory pair and local bus clocks.
   always @(posedge CORE_CLK)
   begin
      if (SRST)
      begin
         mem_div_q <= 1'b0;
         local_cnt_q <= 3'h0;
         local_div_act_q <= `CRS_RST_LOCAL_DIV;
         MEMORY_CLOCK_P <= 1'b0;
         MEMORY_CLOCK_N <= 1'b1;
         LOCAL_BUS_CLOCKS <= 3'h0;
         LOCAL_SYNC_OUT <= 1'b0;
      end
      else
      begin
         mem_div_q <= ~mem_div_q;
         MEMORY_CLOCK_P <= ~mem_div_q;
         MEMORY_CLOCK_N <= mem_div_q;
         local_cnt_q <= local_cnt_d;
         // At the wrap every candidate divider is at a common low edge.
         if (local_cnt_q == `CRS_LCNT_WRAP)
            local_div_act_q <= local_div_q;
         LOCAL_BUS_CLOCKS <= {3{local_clk_d}};
         LOCAL_SYNC_OUT <= local_clk_d;
      end
   end

   // Unit clock enables; new rates take effect only at the frame boundary.
   always @(posedge CORE_CLK)
   begin
      if (SRST)
      begin
         unit_cnt_q <= 3'h0;
         sec_rate_act_q <= `CRS_RST_SEC_RATE;
         dma_on_act_q <= `CRS_RST_DMA_ON;
         SEC_CLK_EN <= 1'b0;
         DMA_CLK_EN <= 1'b0;
      end
      else
      begin
         unit_cnt_q <= unit_cnt_d;
         if (unit_cnt_q == `CRS_UCNT_WRAP)
         begin
            sec_rate_act_q <= sec_rate_q;
            dma_on_act_q <= dma_on_q;
         end
         SEC_CLK_EN <= sec_en_d;
         DMA_CLK_EN <= dma_on_act_q;
      end
   end

   // Avalon-MM slave: one wait cycle, then the access completes.
   always @(posedge CORE_CLK)
   begin
      if (SRST)
      begin
         AVS_WAITREQUEST <= 1'b1;
         AVS_READDATA <= 32'h0;
         out_clk_ctl_q <= `CRS_RST_OUT_CLK_CTL;
         local_div_q <= `CRS_RST_LOCAL_DIV;
         sec_rate_q <= `CRS_RST_SEC_RATE;
         dma_on_q <= `CRS_RST_DMA_ON;
      end
      else
      begin
         if (bus_hit)
         begin
            AVS_WAITREQUEST <= 1'b0;
            AVS_READDATA <= AVS_READ ? rdata_d : 32'h0;
         end
         else
            AVS_WAITREQUEST <= 1'b1;
         if (AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0])
         begin
            case (AVS_ADDRESS)
               `CRS_OFS_OUT_CLK_CTL: out_clk_ctl_q <= AVS_WRITEDATA[2:0];
               `CRS_OFS_LOCAL_RATIO: local_div_q <= AVS_WRITEDATA[1:0];
               `CRS_OFS_UNIT_CLK:
               begin
                  sec_rate_q <= AVS_WRITEDATA[1:0];
                  dma_on_q <= AVS_WRITEDATA[2];
               end
               default: out_clk_ctl_q <= out_clk_ctl_q;
            endcase
         end
      end
   end

endmodule // crs_clock_ratio_select

// ==== tb/crs_asserts.sv ====
// Checker for the clock ratio select block, bound to its top module.
// Assumes the reset words and the strap stay stable after reset release.
`timescale 1ns/1ps
module crs_asserts (
   input wire CORE_CLK,
   input wire SRST,
   input wire [31:0] RESET_CONFIG_LOW,
   input wire [31:0] RESET_CONFIG_HIGH,
   input wire INPUT_HALVE_STRAP,
   input wire OSC_CLOCK_IN,
   input wire AGENT_BUS_CLK,
   input wire SYNC_LOOP_IN,
   input wire AVS_READ,
   input wire AVS_WRITE,
   input wire AVS_WAITREQUEST,
   input wire [1:0] PRIMARY_SEL,
   input wire PRIMARY_CLK,
   input wire SYNC_LOOP_OUT,
   input wire [2:0] BUS_CLOCK_OUTS,
   input wire [5:0] SYSTEM_RATIO,
   input wire [6:0] CORE_PLL_SETTING,
   input wire [4:0] ENGINE_MULT,
   input wire [1:0] ENGINE_DIV,
   input wire [6:0] MEMORY_RATIO,
   input wire [6:0] LOCAL_RATIO,
   input wire MEMORY_CLOCK_P,
   input wire MEMORY_CLOCK_N,
   input wire [2:0] LOCAL_BUS_CLOCKS,
   input wire LOCAL_SYNC_OUT
);
   // Outputs settle a few edges after release, so all checks but the bus handshake wait for the counter to saturate.
   reg [1:0] run_q;
   wire [1:0] run_d = (run_q == 2'h3) ? run_q : run_q + 2'h1;
   wire up = run_q == 2'h3;
   wire [31:0] lo = RESET_CONFIG_LOW;
   wire [1:0] role = RESET_CONFIG_HIGH[31:30];
   wire [4:0] mult = (lo[27:24] == 4'h0) ? 5'h10 : {1'b0, lo[27:24]};
   always @(posedge CORE_CLK)
      run_q <= SRST ? 2'h0 : run_d;
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (SRST);
   sequence req_s;
      (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
   endsequence
   sequence ans_s;
      !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
   endsequence
   a_bus_one_wait: assert property (req_s |=> ans_s)
      else $error("bus answer not after one wait cycle");
   a_host_osc: assert property (up && role == 2'h3 |-> PRIMARY_SEL == 2'h0)
      else $error("host drive source wrong");
   a_agent_src: assert property (up && !role[1] |-> PRIMARY_SEL == 2'h1)
      else $error("agent source wrong");
   a_sync_src: assert property (up && role == 2'h2 |-> PRIMARY_SEL == 2'h2)
      else $error("sync loop source wrong");
   a_prim_follow: assert property (up && PRIMARY_SEL == 2'h0 |-> PRIMARY_CLK == $past(OSC_CLOCK_IN))
      else $error("primary clock not oscillator");
   a_loop_full: assert property (up && role == 2'h3 && !INPUT_HALVE_STRAP |-> SYNC_LOOP_OUT == $past(OSC_CLOCK_IN))
      else $error("sync loop output not oscillator");
   a_bus_quiet: assert property (up && role != 2'h3 |-> BUS_CLOCK_OUTS == 3'h0)
      else $error("bus clocks driven without host drive");
   a_sys_ratio: assert property (up |-> SYSTEM_RATIO == (INPUT_HALVE_STRAP ? {mult, 1'b0} : {1'b0, mult}))
      else $error("system ratio wrong");
   a_derived_ratio: assert property (up |-> MEMORY_RATIO == ({1'b0, SYSTEM_RATIO} << lo[30]) && LOCAL_RATIO == ({1'b0, SYSTEM_RATIO} << lo[31]))
      else $error("memory or local ratio wrong");
   a_engine_core: assert property (up |-> ENGINE_MULT == lo[12:8] && ENGINE_DIV == {lo[6], !lo[6]} && CORE_PLL_SETTING == lo[22:16])
      else $error("engine or core setting wrong");
   a_mem_pair: assert property (up |-> MEMORY_CLOCK_P != MEMORY_CLOCK_N && MEMORY_CLOCK_P != $past(MEMORY_CLOCK_P))
      else $error("memory clock pair not halved");
   a_prim_agent: assert property (up && PRIMARY_SEL == 2'h1 |->
      PRIMARY_CLK == $past(AGENT_BUS_CLK))
      else $error("primary clock not agent bus clock");
   a_prim_sync: assert property (up && PRIMARY_SEL == 2'h2 |->
      PRIMARY_CLK == $past(SYNC_LOOP_IN))
      else $error("primary clock not sync loop input");
   a_loop_quiet: assert property (up && role != 2'h3 |-> !SYNC_LOOP_OUT)
      else $error("sync loop output driven without host drive");
   a_loop_half: assert property (up && role == 2'h3 && INPUT_HALVE_STRAP |->
      (BUS_CLOCK_OUTS & ~{3{SYNC_LOOP_OUT}}) == 3'h0)
      else $error("halved sync loop output not the bus clock");
   a_local_same: assert property (up |-> LOCAL_BUS_CLOCKS == {3{LOCAL_SYNC_OUT}})
      else $error("local bus clocks differ from local sync output");
endmodule // crs_asserts

bind crs_clock_ratio_select crs_asserts i_crs_asserts (.CORE_CLK(CORE_CLK), .SRST(SRST),
   .RESET_CONFIG_LOW(RESET_CONFIG_LOW), .RESET_CONFIG_HIGH(RESET_CONFIG_HIGH),
   .INPUT_HALVE_STRAP(INPUT_HALVE_STRAP), .OSC_CLOCK_IN(OSC_CLOCK_IN), .AVS_READ(AVS_READ),
   .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST), .PRIMARY_SEL(PRIMARY_SEL),
   .PRIMARY_CLK(PRIMARY_CLK), .SYNC_LOOP_OUT(SYNC_LOOP_OUT), .BUS_CLOCK_OUTS(BUS_CLOCK_OUTS),
   .SYSTEM_RATIO(SYSTEM_RATIO), .CORE_PLL_SETTING(CORE_PLL_SETTING), .ENGINE_MULT(ENGINE_MULT),
   .ENGINE_DIV(ENGINE_DIV), .MEMORY_RATIO(MEMORY_RATIO), .LOCAL_RATIO(LOCAL_RATIO),
   .MEMORY_CLOCK_P(MEMORY_CLOCK_P), .MEMORY_CLOCK_N(MEMORY_CLOCK_N),
   .AGENT_BUS_CLK(AGENT_BUS_CLK), .SYNC_LOOP_IN(SYNC_LOOP_IN),
   .LOCAL_BUS_CLOCKS(LOCAL_BUS_CLOCKS), .LOCAL_SYNC_OUT(LOCAL_SYNC_OUT));

// ==== tb/crs_board_clocks.sv ====
// Board clock sources: oscillator, agent bus clock and sync loop input.
// Assumes the bench states the role; edges avoid the core clock's rising edges.
`timescale 1ns/1ps
module crs_board_clocks (
   input wire agent_role,
   output reg osc_clk,
   output reg agent_clk,
   output reg sync_clk
);
   initial
   begin
      osc_clk = 1'b0;
      agent_clk = 1'b0;
      sync_clk = 1'b0;
   end
   // An agent board grounds the oscillator input.
   always #35 osc_clk = agent_role ? 1'b0 : !osc_clk;
   always #40 agent_clk = !agent_clk;
   always #45 sync_clk = !sync_clk;
endmodule // crs_board_clocks

// ==== tb/tb_crs_clock_ratio_select.sv ====
// Self-checking bench for the clock ratio select block.
// Assumes the bound checker and the board clock model beside the design.
`timescale 1ns/1ps
module tb_crs_clock_ratio_select;
   reg core_clk = 1'b0;
   reg srst = 1'b1;
   reg strap = 1'b0;
   reg rd = 1'b0;
   reg wr = 1'b0;
   reg agent = 1'b0;
   reg [31:0] lo = 32'h0;
   reg [31:0] hi = 32'h0;
   reg [31:0] wd = 32'h0;
   reg [3:0] adr = 4'h0;
   reg [3:0] be = 4'hf;
   wire [31:0] rdat;
   wire wt, osc, agc, syc, lsync, sec, dma;
   wire [2:0] bco;
   reg [31:0] expq[$];
   reg [31:0] ex[0:7];
   reg [31:0] tl, th;
   reg ts;
   reg [4:0] mult;
   reg [5:0] sys;
   integer error_cnt = 0;
   integer check_count = 0;
   integer cyc = 0;
   integer k, i, n;

   crs_board_clocks i_crs_board_clocks (.agent_role(agent), .osc_clk(osc), .agent_clk(agc),
      .sync_clk(syc));
   crs_clock_ratio_select i_crs_clock_ratio_select (.CORE_CLK(core_clk), .SRST(srst),
      .RESET_CONFIG_LOW(lo), .RESET_CONFIG_HIGH(hi), .INPUT_HALVE_STRAP(strap),
      .OSC_CLOCK_IN(osc), .AGENT_BUS_CLK(agc), .SYNC_LOOP_IN(syc), .AVS_ADDRESS(adr),
      .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be),
      .AVS_READDATA(rdat), .AVS_WAITREQUEST(wt), .PRIMARY_SEL(), .PRIMARY_CLK(),
      .SYNC_LOOP_OUT(), .BUS_CLOCK_OUTS(bco), .SYSTEM_RATIO(), .CORE_PLL_SETTING(),
      .ENGINE_MULT(), .ENGINE_DIV(), .MEMORY_RATIO(), .LOCAL_RATIO(), .MEMORY_CLOCK_P(),
      .MEMORY_CLOCK_N(), .LOCAL_BUS_CLOCKS(), .LOCAL_SYNC_OUT(lsync), .SEC_CLK_EN(sec),
      .DMA_CLK_EN(dma));

   initial forever #2.5 core_clk = !core_clk;

   task stop_test;
      begin
         $display("checks %0d errors %0d", check_count, error_cnt);
         if (error_cnt == 0 && check_count > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask

   task chk(input string nm, input reg [31:0] e, input reg [31:0] g);
      begin
         check_count = check_count + 1;
         if (g !== e)
         begin
            error_cnt = error_cnt + 1;
            $display("FAIL %s expected %h seen %h", nm, e, g);
         end
      end
   endtask

   // The request is held until waitrequest is sampled low; only the timeout ends a hang.
   task bus(input reg w, input reg [3:0] a, input reg [31:0] d, input reg [3:0] b);
      begin
         adr <= a;
         wd <= d;
         be <= b;
         rd <= !w;
         wr <= w;
         @(posedge core_clk);
         while (wt !== 1'b0)
            @(posedge core_clk);
         rd <= 1'b0;
         wr <= 1'b0;
         @(posedge core_clk);
      end
   endtask

   task rx(input reg [3:0] a, input reg [31:0] e);
      begin
         expq.push_back(e);
         bus(1'b0, a, 32'h0, 4'hf);
      end
   endtask

   // Counts rising edges of the local sync output, or high cycles of the security enable.
   task measure(input integer which, input integer len, output integer cnt);
      reg v, prev;
      integer j;
      begin
         cnt = 0;
         prev = lsync;
         for (j = 0; j < len; j = j + 1)
         begin
            @(posedge core_clk);
            v = which ? sec : lsync;
            if (v === 1'b1 && (which != 0 || prev !== 1'b1))
               cnt = cnt + 1;
            prev = v;
         end
      end
   endtask

   always @(posedge core_clk)
   begin
      cyc = cyc + 1;
      if (cyc == 20000)
      begin
         error_cnt = error_cnt + 1;
         stop_test;
      end
      if (rd && wt === 1'b0 && expq.size() > 0)
         chk("readdata", expq.pop_front(), rdat);
   end

   initial
   begin
      void'($urandom(31));
      // The last pass is a host driving the bus clocks, so the gate test below has clocks.
      for (k = 0; k < 7; k = k + 1)
      begin
         // Random words stand for ratios only; the frequencies they imply are not modelled.
         tl = $urandom;
         th = $urandom;
         if (k < 2)
            tl[27:24] = k[3:0];
         th[31] = (k % 3) != 1;
         th[30] = (k % 3) == 0;
         ts = th[31] & tl[0];
         agent <= !th[31];
         lo <= tl;
         hi <= th;
         strap <= ts;
         srst <= 1'b1;
         repeat (6) @(posedge core_clk);
         srst <= 1'b0;
         @(posedge core_clk);
         mult = (tl[27:24] == 4'h0) ? 5'h10 : {1'b0, tl[27:24]};
         sys = ts ? {mult, 1'b0} : {1'b0, mult};
         ex[0] = tl;
         ex[1] = th;
         ex[2] = 32'h0;
         ex[3] = 32'h0;
         ex[4] = 32'h7;
         ex[5] = {1'b0, tl[27:24] == 4'h1, {1'b0, sys} << tl[31], {1'b0, sys} << tl[30], sys,
            th[31] & th[30], ts, th[31] ? {!th[30], 1'b0} : 2'h1, !tl[6], tl[9:8], 3'h0};
         ex[6] = {9'h0, tl[22:16], 9'h0, tl[6], !tl[6], tl[12:8]};
         ex[7] = 32'h0;
         for (i = 0; i < 8; i = i + 1)
            rx(i[3:0], ex[i]);
         measure(1, 12, n);
         chk("sec default", 32'h4, n);
      end
      bus(1'b1, 4'h0, 32'hffffffff, 4'hf);
      rx(4'h0, tl);
      bus(1'b1, 4'h2, 32'h7, 4'he);
      rx(4'h2, 32'h0);
      bus(1'b1, 4'h2, 32'h5, 4'h1);
      rx(4'h2, 32'h5);
      // Gate 5 passes bits 0 and 2; the oscillator halved is high 28 of every 56 cycles.
      repeat (60) @(posedge core_clk);
      n = 0;
      for (i = 0; i < 56; i = i + 1)
      begin
         @(posedge core_clk);
         if (bco[1] !== 1'b0 || bco[0] !== bco[2])
            n = n + 64;
         if (bco[0] === 1'b1)
            n = n + 1;
      end
      chk("bus gates", 32'd28, n);
      for (i = 0; i < 4; i = i + 1)
      begin
         bus(1'b1, 4'h3, i, 4'hf);
         repeat (16) @(posedge core_clk);
         measure(0, 32, n);
         chk("local rises", 16 >> (i > 2 ? 2 : i), n);
         // Full security rate is written as if the modelled system bus clock met its limit.
         bus(1'b1, 4'h4, {i[0], i[1:0]}, 4'hf);
         repeat (12) @(posedge core_clk);
         measure(1, 12, n);
         chk("sec enables", (i == 0) ? 0 : 12 / i, n);
         chk("dma enable", i[0], dma);
      end
      stop_test;
   end
endmodule // tb_crs_clock_ratio_select
